// [pkg/fln_defines.svh]
// Constants of the floor level network slave port
`ifndef FLN_DEFINES_SVH
`define FLN_DEFINES_SVH
// ****************************************
// Timing
// ****************************************
`define FLN_CLK_HZ          100000000
`define FLN_BAUD_DEFAULT    4800
`define FLN_BAUD_ALT        19200
`define FLN_GAP_TIME_US     2000
`define FLN_US_PER_S        1000000
// ****************************************
// Station addresses
// ****************************************
`define FLN_ADDR_ALL        7'h63
`define FLN_ADDR_MIN        7'h01
`define FLN_ADDR_MAX        7'h63
`define FLN_ADDR_FACTORY    7'h63
// ****************************************
// Register offsets and fields
// ****************************************
`define FLN_REG_CTRL        8'h00
`define FLN_REG_ADDR        8'h04
`define FLN_REG_CTLWORD     8'h08
`define FLN_REG_STATUS      8'h0C
`define FLN_CTRL_BAUD_BIT   0
`define FLN_CTRL_REPLY_BIT  1
`define FLN_ADDR_EFF_LSB    8
`define FLN_ADDR_LOCK_BIT   16
`define FLN_STAT_CNT_LSB    16
// ****************************************
// Control word bits and points
// ****************************************
`define FLN_CW_RUN          4'h0
`define FLN_CW_ENABLE       4'h3
`define FLN_CW_FAULT_ACK    4'h7
`define FLN_CW_REVERSE      4'hB
`define FLN_PT_WORD         8'h00
`define FLN_PT_CMD_START    8'h18
`define FLN_PT_RUN_ENABLE   8'h23
`define FLN_PT_FAULT_ACK    8'h5F
`define FLN_PT_CMD_FWD_REV  8'h16
`define FLN_PT_ENABLED      8'h24
`define FLN_PT_READY        8'h1C
`define FLN_PT_STOP_RUN     8'h19
`define FLN_PT_FAULT        8'h5E
`define FLN_PT_WARNING      8'h60
`define FLN_PT_CTRL_MODE    8'h1A
`define FLN_PT_AT_MAX       8'h15
`define FLN_PT_FWD_REV      8'h17
`define FLN_TELE_LAST       3'h3
`define FLN_REPLY_SHORT     3'h3
`define FLN_REPLY_LONG      3'h5
`endif

// [pkg/fln_pkg.sv]
// Types of the floor level network slave port
package fln_pkg;
  // ****************************************
  // States
  // ****************************************
  typedef enum logic [1:0] {FLN_ST_LOAD, FLN_ST_RECV, FLN_ST_REPLY} fln_state_t;
  typedef enum logic [1:0] {FLN_SER_IDLE, FLN_SER_START, FLN_SER_DATA, FLN_SER_STOP} fln_ser_t;
  // ****************************************
  // Module state records
  // ****************************************
  typedef struct packed {
    fln_ser_t    st;
    logic [15:0] cnt;
    logic [2:0]  bit_idx;
    logic [7:0]  shift;
    logic [7:0]  data;
    logic        valid;
    logic        frame_err;
  } fln_rx_t;
  typedef struct packed {
    fln_ser_t    st;
    logic [15:0] cnt;
    logic [2:0]  bit_idx;
    logic [7:0]  shift;
    logic        txd;
  } fln_tx_t;
  typedef struct packed {
    fln_state_t  st;
    logic [2:0]  byte_idx;
    logic        matched;
    logic [7:0]  point;
    logic [7:0]  data_lo;
    logic [15:0] ctl_word;
    logic [6:0]  sw_addr;
    logic [6:0]  eff_addr;
    logic        locked;
    logic        baud_sel;
    logic        reply_sel;
    logic [2:0]  tx_idx;
    logic [15:0] reply_word;
    logic [15:0] speed;
    logic [19:0] gap_cnt;
    logic [7:0]  tele_cnt;
    logic [7:0]  err_cnt;
    logic        wb_ack;
    logic [31:0] wb_rdata;
  } fln_core_t;
endpackage : fln_pkg

// [core/fln_uart_rx.sv]
// Serial byte receiver, 8 data bits, no parity, one stop bit
`timescale 1ns/100ps
`include "fln_defines.svh"
module fln_uart_rx import fln_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] bit_div,
  input  wire logic        rxd,
  output logic [7:0]       data,
  output logic             valid,
  output logic             frame_err
);
  fln_rx_t r_reg;
  fln_rx_t r_next;
  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    r_next = r_reg;
    r_next.valid = 1'b0;
    r_next.frame_err = 1'b0;
    case (r_reg.st)
      FLN_SER_IDLE: begin
        if (!rxd) begin
          r_next.st = FLN_SER_START;
          r_next.cnt = {1'b0, bit_div[15:1]};
        end
      end
      FLN_SER_START: begin
        // Sample mid bit, a short glitch falls back to idle
        if (r_reg.cnt == 16'h0000) begin
          r_next.st = rxd ? FLN_SER_IDLE : FLN_SER_DATA;
          r_next.cnt = bit_div - 16'h0001;
          r_next.bit_idx = 3'h0;
        end else r_next.cnt = r_reg.cnt - 16'h0001;
      end
      FLN_SER_DATA: begin
        if (r_reg.cnt == 16'h0000) begin
          r_next.shift = {rxd, r_reg.shift[7:1]};
          r_next.cnt = bit_div - 16'h0001;
          if (r_reg.bit_idx == 3'h7) r_next.st = FLN_SER_STOP;
          else r_next.bit_idx = r_reg.bit_idx + 3'h1;
        end else r_next.cnt = r_reg.cnt - 16'h0001;
      end
      FLN_SER_STOP: begin
        if (r_reg.cnt == 16'h0000) begin
          r_next.st = FLN_SER_IDLE;
          r_next.data = r_reg.shift;
          r_next.valid = rxd;
          r_next.frame_err = !rxd;
        end else r_next.cnt = r_reg.cnt - 16'h0001;
      end
      default: r_next.st = FLN_SER_IDLE;
    endcase
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) r_reg <= '0;
    else r_reg <= r_next;
  end
  assign data = r_reg.data;
  assign valid = r_reg.valid;
  assign frame_err = r_reg.frame_err;
endmodule : fln_uart_rx

// [core/fln_uart_tx.sv]
// Serial byte transmitter, 8 data bits, no parity, one stop bit
`timescale 1ns/100ps
`include "fln_defines.svh"
module fln_uart_tx import fln_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] bit_div,
  input  wire logic        start,
  input  wire logic [7:0]  data,
  output logic             ready,
  output logic             txd
);
  fln_tx_t t_reg;
  fln_tx_t t_next;
  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    t_next = t_reg;
    case (t_reg.st)
      FLN_SER_IDLE: begin
        t_next.txd = 1'b1;
        if (start) begin
          t_next.st = FLN_SER_START;
          t_next.shift = data;
          t_next.cnt = bit_div - 16'h0001;
          t_next.txd = 1'b0;
        end
      end
      FLN_SER_START: begin
        if (t_reg.cnt == 16'h0000) begin
          t_next.st = FLN_SER_DATA;
          t_next.txd = t_reg.shift[0];
          t_next.bit_idx = 3'h0;
          t_next.cnt = bit_div - 16'h0001;
        end else t_next.cnt = t_reg.cnt - 16'h0001;
      end
      FLN_SER_DATA: begin
        if (t_reg.cnt == 16'h0000) begin
          t_next.cnt = bit_div - 16'h0001;
          if (t_reg.bit_idx == 3'h7) begin
            t_next.st = FLN_SER_STOP;
            t_next.txd = 1'b1;
          end else begin
            t_next.bit_idx = t_reg.bit_idx + 3'h1;
            t_next.shift = {1'b0, t_reg.shift[7:1]};
            t_next.txd = t_reg.shift[1];
          end
        end else t_next.cnt = t_reg.cnt - 16'h0001;
      end
      FLN_SER_STOP: begin
        if (t_reg.cnt == 16'h0000) t_next.st = FLN_SER_IDLE;
        else t_next.cnt = t_reg.cnt - 16'h0001;
      end
      default: t_next.st = FLN_SER_IDLE;
    endcase
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) t_reg <= '{st: FLN_SER_IDLE, txd: 1'b1, default: '0};
    else t_reg <= t_next;
  end
  assign ready = (t_reg.st == FLN_SER_IDLE);
  assign txd = t_reg.txd;
endmodule : fln_uart_tx

// [core/fln_slave_port.sv]
// Floor level network slave port with Wishbone configuration registers
// Operation
// R1 - Reply only to a telegram carrying this station's address.
// R2 - Never start a transfer; only answer the master.
// R3 - Master attaches at most thirty-two slaves per network port.
// R4 - Line runs 4800 bit/s by default, 19200 bit/s selectable.
// R5 - Run command comes from control word bit 0.
// R6 - Operation enable comes from control word bit 3.
// R7 - Fault acknowledge comes from control word bit 7.
// R8 - Accept and answer telegrams to station 99 always.
// R9 - Only addresses 1 through 99 are valid configured addresses.
// R10 - Valid switch address wins and locks software setting; factory value 99.
// R11 - New address takes effect only at next power-up; reset restores sw_addr to 99, so a software address never does.
// R12 - Reply may carry status word then actual speed.
// R13 - Points map to fixed control or status word bits.
// R14 - Ignore foreign telegrams without replying.
`timescale 1ns/100ps
`include "fln_defines.svh"
module fln_slave_port import fln_pkg::*; #(
  parameter int BAUD_DIV_DEFAULT = `FLN_CLK_HZ / `FLN_BAUD_DEFAULT,
  parameter int BAUD_DIV_ALT     = `FLN_CLK_HZ / `FLN_BAUD_ALT,
  parameter int GAP_CYCLES       = `FLN_GAP_TIME_US * (`FLN_CLK_HZ / `FLN_US_PER_S)
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [31:0] wb_adr,
  input  wire logic [31:0] wb_wdata,
  output logic [31:0]      wb_rdata,
  input  wire logic [3:0]  wb_sel,
  input  wire logic        wb_we,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  output logic             wb_ack,
  input  wire logic [6:0]  addr_switch,
  input  wire logic        rx_line,
  output logic             tx_line,
  output logic             tx_oe,
  input  wire logic [15:0] status_word,
  input  wire logic [15:0] speed_actual,
  output logic [15:0]      control_word,
  output logic             run_command,
  output logic             operation_enable,
  output logic             fault_ack
);
  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic addr_valid(input logic [6:0] a);
    addr_valid = (a >= `FLN_ADDR_MIN) && (a <= `FLN_ADDR_MAX);
  endfunction : addr_valid

  // Returns {hit, bit index} for a digital output point
  function automatic logic [4:0] out_point(input logic [7:0] p);
    case (p)
      `FLN_PT_CMD_START:   out_point = {1'b1, `FLN_CW_RUN};
      `FLN_PT_RUN_ENABLE:  out_point = {1'b1, `FLN_CW_ENABLE};
      `FLN_PT_FAULT_ACK:   out_point = {1'b1, `FLN_CW_FAULT_ACK};
      `FLN_PT_CMD_FWD_REV: out_point = {1'b1, `FLN_CW_REVERSE};
      default:             out_point = 5'h00;
    endcase
  endfunction : out_point

  // Returns {hit, bit index} for a digital input point
  function automatic logic [4:0] in_point(input logic [7:0] p);
    case (p)
      `FLN_PT_ENABLED:   in_point = 5'h10;
      `FLN_PT_READY:     in_point = 5'h11;
      `FLN_PT_STOP_RUN:  in_point = 5'h12;
      `FLN_PT_FAULT:     in_point = 5'h13;
      `FLN_PT_WARNING:   in_point = 5'h17;
      `FLN_PT_CTRL_MODE: in_point = 5'h19;
      `FLN_PT_AT_MAX:    in_point = 5'h1A;
      `FLN_PT_FWD_REV:   in_point = 5'h1E;
      default:           in_point = 5'h00;
    endcase
  endfunction : in_point

  // ****************************************
  // Serial line
  // ****************************************
  fln_core_t   c_reg;
  fln_core_t   c_next;

  logic [15:0] bit_div;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        rx_ferr;

  logic        tx_ready;
  logic        tx_start;
  logic [7:0]  tx_byte;
  logic [2:0]  tx_len;

  logic [4:0]  op_hit;
  logic [4:0]  ip_hit;
  logic        wb_req;
  logic [7:0]  wb_off;

  assign bit_div = c_reg.baud_sel ? BAUD_DIV_ALT[15:0] : BAUD_DIV_DEFAULT[15:0]; // R4

  fln_uart_rx u_rx (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .bit_div   (bit_div),
    .rxd       (rx_line),
    .data      (rx_data),
    .valid     (rx_valid),
    .frame_err (rx_ferr)
  );

  fln_uart_tx u_tx (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .bit_div  (bit_div),
    .start    (tx_start),
    .data     (tx_byte),
    .ready    (tx_ready),
    .txd      (tx_line)
  );

  // ****************************************
  // Reply framing
  // ****************************************
  assign tx_len = c_reg.reply_sel ? `FLN_REPLY_LONG : `FLN_REPLY_SHORT; // R12
  // Transmit is reachable only from a matched telegram
  assign tx_start = (c_reg.st == FLN_ST_REPLY) && tx_ready && (c_reg.tx_idx != tx_len); // R1 R2
  // Driver stays on between reply bytes so the line does not float
  assign tx_oe = (c_reg.st == FLN_ST_REPLY);

  always_comb begin
    case (c_reg.tx_idx)
      3'h0:    tx_byte = {1'b0, c_reg.eff_addr};
      3'h1:    tx_byte = c_reg.reply_word[7:0];
      3'h2:    tx_byte = c_reg.reply_word[15:8];
      3'h3:    tx_byte = c_reg.speed[7:0];
      3'h4:    tx_byte = c_reg.speed[15:8];
      default: tx_byte = 8'h00;
    endcase
  end

  assign op_hit = out_point(c_reg.point);
  assign ip_hit = in_point(c_reg.point);
  assign wb_req = wb_cyc && wb_stb && !c_reg.wb_ack;
  assign wb_off = wb_adr[7:0];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    c_next = c_reg;
    c_next.wb_ack = wb_req;
    if (rx_ferr) begin
      c_next.err_cnt = c_reg.err_cnt + 8'h01;
    end

    // Telegram resync after a silent gap
    if (rx_valid) begin
      c_next.gap_cnt = 20'h00000;
    end else if (c_reg.gap_cnt != GAP_CYCLES[19:0]) begin
      c_next.gap_cnt = c_reg.gap_cnt + 20'h00001;
    end
    if (c_reg.gap_cnt == GAP_CYCLES[19:0] - 20'h00001) begin
      c_next.byte_idx = 3'h0;
    end

    case (c_reg.st)
      FLN_ST_LOAD: begin
        // Address chosen once after power-up only
        if (addr_valid(addr_switch)) begin
          c_next.eff_addr = addr_switch; // R10 R11
        end else begin
          c_next.eff_addr = c_reg.sw_addr; // R10 R11
        end
        c_next.st = FLN_ST_RECV;
      end

      FLN_ST_RECV: begin
        if (rx_valid) begin
          case (c_reg.byte_idx)
            3'h0: begin
              // Foreign frames are still counted through so the next one aligns
              c_next.matched = !rx_data[7] &&
                ((rx_data[6:0] == c_reg.eff_addr) || (rx_data[6:0] == `FLN_ADDR_ALL)); // R8 R14
              c_next.byte_idx = 3'h1;
            end

            3'h1: begin
              c_next.point = rx_data;
              c_next.byte_idx = 3'h2;
            end

            3'h2: begin
              c_next.data_lo = rx_data;
              c_next.byte_idx = `FLN_TELE_LAST;
            end

            default: begin
              c_next.byte_idx = 3'h0;
              if (c_reg.matched) begin // R1 R14
                c_next.st = FLN_ST_REPLY;
                c_next.tx_idx = 3'h0;
                c_next.tele_cnt = c_reg.tele_cnt + 8'h01;
                c_next.reply_word = status_word; // R12
                c_next.speed = speed_actual; // R12
                if (c_reg.point == `FLN_PT_WORD) begin
                  c_next.ctl_word = {rx_data, c_reg.data_lo};
                end else if (op_hit[4]) begin
                  c_next.ctl_word[op_hit[3:0]] = c_reg.data_lo[0]; // R13
                end else if (ip_hit[4]) begin
                  c_next.reply_word = {15'h0000, status_word[ip_hit[3:0]]}; // R13
                end
              end
            end
          endcase
        end
      end

      FLN_ST_REPLY: begin
        // Own echo on the half duplex line is not parsed here
        if (tx_ready) begin
          if (c_reg.tx_idx == tx_len) begin
            c_next.st = FLN_ST_RECV;
            c_next.byte_idx = 3'h0;
          end else begin
            c_next.tx_idx = c_reg.tx_idx + 3'h1;
          end
        end
      end

      default: begin
        c_next.st = FLN_ST_LOAD;
      end
    endcase

    // ****************************************
    // Register bus
    // ****************************************
    c_next.locked = addr_valid(addr_switch); // R10
    if (wb_req && wb_we && wb_sel[0]) begin
      case (wb_off)
        `FLN_REG_CTRL: begin
          c_next.baud_sel = wb_wdata[`FLN_CTRL_BAUD_BIT]; // R4
          c_next.reply_sel = wb_wdata[`FLN_CTRL_REPLY_BIT]; // R12
        end

        `FLN_REG_ADDR: begin
          // Out of range values are refused; reset restores sw_addr to 99, so a written value never takes effect
          // Live switches, so a write in the cycle they turn valid is refused too
          if (!addr_valid(addr_switch) && addr_valid(wb_wdata[6:0])) begin // R9 R10 R11
            c_next.sw_addr = wb_wdata[6:0];
          end
        end

        default: begin
          // Read only and unmapped offsets ignore writes
        end
      endcase
    end

    if (wb_req && !wb_we) begin
      case (wb_off)
        `FLN_REG_CTRL: begin
          c_next.wb_rdata = {30'h00000000, c_reg.reply_sel, c_reg.baud_sel};
        end
        `FLN_REG_ADDR: begin
          c_next.wb_rdata = {15'h0000, c_reg.locked, 1'b0, c_reg.eff_addr,
                             1'b0, c_reg.sw_addr};
        end
        `FLN_REG_CTLWORD: begin
          c_next.wb_rdata = {16'h0000, c_reg.ctl_word};
        end
        `FLN_REG_STATUS: begin
          c_next.wb_rdata = {c_reg.err_cnt, c_reg.tele_cnt, status_word};
        end
        default: begin
          c_next.wb_rdata = 32'h00000000;
        end
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      c_reg <= '{st: FLN_ST_LOAD, sw_addr: `FLN_ADDR_FACTORY,
                 eff_addr: `FLN_ADDR_FACTORY, default: '0}; // R10
    end else begin
      c_reg <= c_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wb_ack = c_reg.wb_ack;
  assign wb_rdata = c_reg.wb_rdata;

  assign control_word = c_reg.ctl_word;
  assign run_command = c_reg.ctl_word[`FLN_CW_RUN]; // R5
  assign operation_enable = c_reg.ctl_word[`FLN_CW_ENABLE]; // R6
  assign fault_ack = c_reg.ctl_word[`FLN_CW_FAULT_ACK]; // R7
endmodule : fln_slave_port

// [sim/fln_slave_port_properties.sv]
// Port assertions for the floor network slave port
`timescale 1ns/100ps
module fln_slave_port_props (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        wb_cyc,
  input wire logic        wb_stb,
  input wire logic        wb_ack,
  input wire logic        tx_line,
  input wire logic        tx_oe,
  input wire logic [15:0] control_word,
  input wire logic        run_command,
  input wire logic        operation_enable,
  input wire logic        fault_ack
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ****************************************
  // Line and control word relations
  // ****************************************
  property p_run; run_command == control_word[0]; endproperty
  a_run: assert property (p_run) else $error("run off word");
  property p_enable; operation_enable == control_word[3]; endproperty
  a_enable: assert property (p_enable) else $error("enable off word");
  property p_fack; fault_ack == control_word[7]; endproperty
  a_fack: assert property (p_fack) else $error("fault ack off word");
  // Released line must look idle, else the master sees a phantom start
  property p_quiet; !tx_oe |-> tx_line; endproperty
  a_quiet: assert property (p_quiet) else $error("line active outside reply");
  property p_start; $rose(tx_oe) |-> ##[0:1] !tx_line; endproperty
  a_start: assert property (p_start) else $error("reply without start bit");
  // Eight cycles is the shortest bit of both simulated rates
  property p_bit; $fell(tx_line) |-> !tx_line [*8]; endproperty
  a_bit: assert property (p_bit) else $error("bit too short");
  property p_cw_hold; tx_oe && $past(tx_oe) |-> $stable(control_word); endproperty
  a_cw_hold: assert property (p_cw_hold) else $error("word changed in reply");
  property p_ack; wb_cyc && wb_stb && !wb_ack |=> wb_ack; endproperty
  a_ack: assert property (p_ack) else $error("bus request not acked");
endmodule : fln_slave_port_props

// [sim/fln_master_model.sv]
// Master controller model on the serial line
`timescale 1ns/100ps
module fln_master_model (
  input  wire logic        core_clk,
  input  wire logic [15:0] bit_div,
  input  wire logic        line_in,
  output logic             line_out
);
  initial line_out = 1'h1;
  // ****************************************
  // Byte transfer, 8N1, LSB first
  // ****************************************
  // Short stop on a last byte so the reply start is not missed
  task automatic send_byte(input logic [7:0] b, input int stop_len);
    line_out <= 1'h0;
    repeat (bit_div) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      line_out <= b[i];
      repeat (bit_div) @(posedge core_clk);
    end
    line_out <= 1'h1;
    repeat (stop_len) @(posedge core_clk);
  endtask : send_byte
  task automatic recv_byte(output logic [7:0] b, output logic got);
    int n;
    got = 1'h0;
    b = 8'h00;
    n = 0;
    while (line_in !== 1'h0 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    if (line_in === 1'h0) begin
      repeat (bit_div / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_div) @(posedge core_clk);
        b[i] = line_in;
      end
      repeat (bit_div) @(posedge core_clk);
      got = line_in;
    end
  endtask : recv_byte
endmodule : fln_master_model

// [sim/tb_floor_network_slave_port.sv]
// Self-checking bench for the floor network slave port
`timescale 1ns/100ps
`include "fln_defines.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_floor_network_slave_port;
  localparam logic [15:0] ST_PAT = 16'h4285;
  localparam logic [15:0] SP_PAT = 16'h1234;
  localparam logic [31:0] PO     = 32'h165F2318;
  localparam logic [15:0] BO     = 16'hB730;
  localparam logic [63:0] PI     = 64'h17151A605E191C24;
  localparam logic [31:0] BI     = 32'hEA973210;
  logic        core_clk    = 1'h0;
  logic        sys_rst     = 1'h1;
  logic [31:0] wb_adr      = 32'h0;
  logic [31:0] wb_wdata    = 32'h0;
  logic [31:0] wb_rdata;
  logic        wb_we       = 1'h0;
  logic        wb_cyc      = 1'h0;
  logic        wb_stb      = 1'h0;
  logic        wb_ack;
  logic [6:0]  addr_switch = 7'h00;
  logic        rx_line;
  logic        tx_line;
  logic        tx_oe;
  logic [15:0] control_word;
  logic        run_command;
  logic        operation_enable;
  logic        fault_ack;
  logic [15:0] div_sel     = 16'h0010;
  logic [31:0] rd_data;
  // Line bias holds a released line at idle
  wire         m_line      = tx_oe ? tx_line : 1'h1;
  int          n_errors    = 0;
  int          comparisons = 0;
  always #5 core_clk = ~core_clk;
  fln_slave_port #(.BAUD_DIV_DEFAULT(16), .BAUD_DIV_ALT(8), .GAP_CYCLES(2000)) u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .wb_adr(wb_adr), .wb_wdata(wb_wdata),
    .wb_rdata(wb_rdata), .wb_sel(4'hF), .wb_we(wb_we), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_ack(wb_ack), .addr_switch(addr_switch), .rx_line(rx_line), .tx_line(tx_line),
    .tx_oe(tx_oe), .status_word(ST_PAT), .speed_actual(SP_PAT), .control_word(control_word),
    .run_command(run_command), .operation_enable(operation_enable), .fault_ack(fault_ack));
  // One slave only on this master port
  fln_master_model u_master (.core_clk(core_clk), .bit_div(div_sel), .line_in(m_line),
    .line_out(rx_line));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  task automatic do_reset;
    sys_rst <= 1'h1;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'h0;
    repeat (2) @(posedge core_clk);
  endtask : do_reset
  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] wd);
    int n;
    n = 0;
    wb_adr <= {24'h0, a};
    wb_we <= we;
    wb_wdata <= wd;
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack !== 1'h1 && n < 20);
    `CHK(wb_ack, 1'h1)
    rd_data = wb_rdata;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    wb_we <= 1'h0;
    @(posedge core_clk);
  endtask : wb
  // Bytes of exp go low first; no reply is expected when nexp is zero
  task automatic xchg(input logic [31:0] tel, input int nexp, input logic [39:0] exp);
    logic [7:0] b;
    logic       got;
    int         n;
    for (int i = 0; i < 4; i++) begin
      u_master.send_byte(tel[8*i+:8], i == 3 ? 1 : int'(div_sel));
    end
    for (int i = 0; i < nexp; i++) begin
      u_master.recv_byte(b, got);
      `CHK(got, 1'h1)
      `CHK(b, exp[8*i+:8])
    end
    if (nexp == 0) begin
      u_master.recv_byte(b, got);
      `CHK(got, 1'h0)
    end
    n = 0;
    while (tx_oe !== 1'h0 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    `CHK(tx_oe, 1'h0)
    repeat (4) @(posedge core_clk);
  endtask : xchg
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    `CHK(tx_line, 1'h1)
    `CHK(control_word, 16'h0000)
    wb(`FLN_REG_ADDR, 1'h0, 32'h0);
    `CHK(rd_data, 32'h00006363)
    wb(`FLN_REG_CTRL, 1'h0, 32'h0);
    `CHK(rd_data, 32'h00000000)
    wb(8'h10, 1'h0, 32'h0);
    `CHK(rd_data, 32'h00000000)
    $display("t_reset done");
  endtask : t_reset
  task automatic t_walk;
    xchg(32'h00810063, 3, {16'h0, ST_PAT, 8'h63});
    `CHK(control_word, 16'h0081)
    `CHK(run_command, 1'h1)
    `CHK(fault_ack, 1'h1)
    `CHK(operation_enable, 1'h0)
    wb(`FLN_REG_CTLWORD, 1'h0, 32'h0);
    `CHK(rd_data, 32'h00000081)
    $display("t_walk done");
  endtask : t_walk
  task automatic t_points;
    logic [15:0] exp_cw;
    exp_cw = 16'h0000;
    xchg(32'h00000063, 3, {16'h0, ST_PAT, 8'h63});
    for (int i = 0; i < 4; i++) begin
      exp_cw[BO[4*i+:4]] = 1'h1;
      xchg({16'h0001, PO[8*i+:8], 8'h63}, 3, {16'h0, ST_PAT, 8'h63});
      `CHK(control_word, exp_cw)
    end
    `CHK(operation_enable, 1'h1)
    for (int i = 0; i < 8; i++) begin
      xchg({16'h0, PI[8*i+:8], 8'h63}, 3, {16'h0, 15'h0, ST_PAT[BI[4*i+:4]], 8'h63});
    end
    $display("t_points done");
  endtask : t_points
  task automatic t_foreign;
    logic [15:0] cw;
    cw = control_word;
    xchg(32'hFFFF0005, 0, 40'h0);
    `CHK(control_word, cw)
    $display("t_foreign done");
  endtask : t_foreign
  task automatic t_addr;
    wb(`FLN_REG_ADDR, 1'h1, 32'h0000000C);
    wb(`FLN_REG_ADDR, 1'h0, 32'h0);
    `CHK(rd_data, 32'h0000630C)
    xchg(32'h0000400C, 0, 40'h0);
    addr_switch <= 7'h14;
    wb(`FLN_REG_ADDR, 1'h1, 32'h0000001E);
    wb(`FLN_REG_ADDR, 1'h0, 32'h0);
    `CHK(rd_data, 32'h0001630C)
    do_reset;
    wb(`FLN_REG_ADDR, 1'h0, 32'h0);
    `CHK(rd_data, 32'h00011463)
    xchg(32'h00004014, 3, {16'h0, ST_PAT, 8'h14});
    xchg(32'h00004063, 3, {16'h0, ST_PAT, 8'h14});
    addr_switch <= 7'h64;
    do_reset;
    wb(`FLN_REG_ADDR, 1'h1, 32'h00000000);
    wb(`FLN_REG_ADDR, 1'h0, 32'h0);
    `CHK(rd_data, 32'h00006363)
    xchg(32'h00004014, 0, 40'h0);
    $display("t_addr done");
  endtask : t_addr
  task automatic t_long;
    wb(`FLN_REG_CTRL, 1'h1, 32'h00000003);
    div_sel <= 16'h0008;
    wb(`FLN_REG_CTRL, 1'h0, 32'h0);
    `CHK(rd_data, 32'h00000003)
    xchg(32'h00004063, 5, {SP_PAT, ST_PAT, 8'h63});
    wb(`FLN_REG_STATUS, 1'h0, 32'h0);
    `CHK(rd_data, {16'h0001, ST_PAT})
    $display("t_long done");
  endtask : t_long
  initial begin
    do_reset;
    t_reset;
    t_walk;
    t_points;
    t_foreign;
    t_addr;
    t_long;
    final_report;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    final_report;
  end
endmodule : tb_floor_network_slave_port
bind fln_slave_port fln_slave_port_props u_props (.core_clk(core_clk), .sys_rst(sys_rst),
  .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_ack(wb_ack), .tx_line(tx_line), .tx_oe(tx_oe),
  .control_word(control_word), .run_command(run_command),
  .operation_enable(operation_enable), .fault_ack(fault_ack));
